// ===== include/nv_host_pkg.sv
// Purpose: constants and types for the non-volatile SRAM host controller
// Assumes: 50 MHz core_clk, synchronous active-high reset
// Notes: all pin timing is counted in core_clk cycles
// Functional notes
// - Write needs select and write low, nv high; host holds address stable.
// - Host keeps output gate high for the whole write.
// - Host holds address lines stable during a recall.
// - Software store: reads 0000,1555,0AAA,1FFF,10F0,0F0F in order.
// - Host uses read cycles only, write strobe high, for the sequence.
package nv_host_pkg;

  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;

  // Pin phase timing in ns, nv copy and restore times in us, and derived cycle counts
  localparam int CLK_NS = 20;
  localparam int ACCESS_NS = 45;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int NV_COPY_TIME_US = 10000;
  localparam int NV_RESTORE_DURATION_US = 20;
  localparam int NV_COPY_CYC = NV_COPY_TIME_US * 1000 / CLK_NS;
  localparam int NV_RESTORE_CYC = NV_RESTORE_DURATION_US * 1000 / CLK_NS;

  // Software sequence addresses
  localparam logic [12:0] SEQ_A0 = 13'h0000;
  localparam logic [12:0] SEQ_A1 = 13'h1555;
  localparam logic [12:0] SEQ_A2 = 13'h0aaa;
  localparam logic [12:0] SEQ_A3 = 13'h1fff;
  localparam logic [12:0] SEQ_A4 = 13'h10f0;
  localparam logic [12:0] SEQ_STORE = 13'h0f0f;
  localparam logic [12:0] SEQ_RECALL = 13'h0f0e;

  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_HW_STORE, OP_HW_RECALL, OP_SW_STORE, OP_SW_RECALL
  } op_t;

  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cmd_t;

  typedef struct packed {
    logic chip_select_n;
    logic output_gate_n;
    logic write_strobe_n;
    logic nonvolatile_strobe_n;
  } ctl_pins_t;

endpackage : nv_host_pkg

// ===== hw/nv_host_ctrl.sv
// Purpose: host controller driving a non-volatile SRAM through its pins
// Assumes: one command at a time, data pins modelled as in/out/enable
// Notes: long waits are top-level parameters so simulation can shorten them
`timescale 1ns/1ns
`default_nettype none
module nv_host_ctrl
  import nv_host_pkg::*;
#(
  parameter int COPY_CYC = NV_COPY_CYC,
  parameter int RESTORE_CYC = NV_RESTORE_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output ctl_pins_t ctl,
  output logic [ADDR_W-1:0] address_lines,
  input wire logic [DATA_W-1:0] data_lines_in,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe_n
);

  // Boot waits out the power-up recall; access runs all but the software commands,
  // release runs every command, wait follows store and recall; the sequence state walks the six software reads
  typedef enum logic [2:0] {
    S_BOOT, S_IDLE, S_ACCESS, S_RELEASE, S_WAIT, S_SEQ
  } state_t;

  // Working registers and their next values
  state_t state, next_state;
  cmd_t cur, next_cur;
  logic [31:0] cnt, next_cnt;
  logic [2:0] step, next_step;
  ctl_pins_t next_ctl;
  logic [ADDR_W-1:0] next_address_lines;
  logic [DATA_W-1:0] next_data_lines_out, next_rsp_data;
  logic next_data_lines_oe_n, next_cmd_ready, next_rsp_valid;

  // All strobes high: device deselected, no nv cycle pending
  localparam ctl_pins_t CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1};

  ////////////////////////////////////////////////////////////////////////
  // Address of sequence step n; sixth picks store or recall
  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] n,
                                                  input op_t op);
    unique case (n)
      3'h0: seq_addr = SEQ_A0;
      3'h1: seq_addr = SEQ_A1;
      3'h2: seq_addr = SEQ_A2;
      3'h3: seq_addr = SEQ_A3;
      3'h4: seq_addr = SEQ_A4;
      default: seq_addr = (op == OP_SW_STORE) ? SEQ_STORE : SEQ_RECALL;
    endcase
  endfunction : seq_addr

  // Pin pattern for one access phase
  function automatic ctl_pins_t phase_ctl(input op_t op);
    ctl_pins_t c;
    c = CTL_IDLE;
    unique case (op)
      OP_READ, OP_SW_STORE, OP_SW_RECALL: begin
        c.chip_select_n = 1'b0;
        c.output_gate_n = 1'b0;
      end
      OP_WRITE: begin
        c.chip_select_n = 1'b0; // gate high
        c.write_strobe_n = 1'b0;
      end
      OP_HW_STORE: begin
        c.chip_select_n = 1'b0;
        c.write_strobe_n = 1'b0;
        c.nonvolatile_strobe_n = 1'b0; // falling edge from idle
      end
      OP_HW_RECALL: begin
        c.chip_select_n = 1'b0;
        c.output_gate_n = 1'b0;
        c.nonvolatile_strobe_n = 1'b0; // fresh edge each time
      end
    endcase
    phase_ctl = c;
  endfunction : phase_ctl

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    next_state = state;
    next_cur = cur;
    next_cnt = cnt;
    next_step = step;
    next_ctl = ctl;
    next_address_lines = address_lines;
    next_data_lines_out = data_lines_out;
    next_data_lines_oe_n = data_lines_oe_n;
    next_cmd_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    unique case (state)
      S_BOOT: begin
        // Power-up recall blocks access
        if (cnt >= 32'(RESTORE_CYC)) begin
          next_state = S_IDLE;
          next_cmd_ready = 1'b1;
        end else begin
          next_cnt = cnt + 32'h1;
        end
      end
      S_IDLE: begin
        // Ready only here, so requests are refused while busy
        next_cmd_ready = 1'b1;
        if (cmd_valid && cmd_ready) begin
          next_cmd_ready = 1'b0;
          next_cur = cmd;
          next_cnt = 32'h0;
          next_step = 3'h0;
          if (cmd.op == OP_SW_STORE || cmd.op == OP_SW_RECALL) begin
            next_address_lines = seq_addr(3'h0, cmd.op);
            next_ctl = phase_ctl(cmd.op);
            next_state = S_SEQ;
          end else begin
            next_address_lines = cmd.addr;
            next_ctl = phase_ctl(cmd.op);
            next_data_lines_out = cmd.wdata;
            next_data_lines_oe_n = (cmd.op != OP_WRITE);
            next_state = S_ACCESS;
          end
        end
      end
      S_ACCESS: begin
        // Hold address and strobes for the access time
        if (cnt >= 32'(ACCESS_CYC)) begin
          next_rsp_data = data_lines_in;
          next_ctl = CTL_IDLE;
          next_data_lines_oe_n = 1'b1;
          next_cnt = 32'h0;
          next_state = S_RELEASE;
        end else begin
          next_cnt = cnt + 32'h1;
        end
      end
      S_SEQ: begin
        // One read per step, address held constant
        if (cnt >= 32'(ACCESS_CYC)) begin
          next_cnt = 32'h0;
          if (ctl.chip_select_n) begin
            // Address settled during the gap; select falls on it
            next_step = step + 3'h1;
            next_ctl = phase_ctl(cur.op);
          end else if (step == 3'h5) begin
            next_ctl = CTL_IDLE;
            next_state = S_RELEASE;
          end else begin
            // Skewed address bits land while deselected
            next_ctl = CTL_IDLE; // select high between reads
            next_address_lines = seq_addr(step + 3'h1, cur.op);
          end
        end else begin
          next_cnt = cnt + 32'h1;
        end
      end
      S_RELEASE: begin
        // Strobes already high, so the next trigger is a fresh edge
        next_cnt = 32'h0;
        if (cur.op == OP_READ || cur.op == OP_WRITE) begin
          next_rsp_valid = 1'b1;
          next_cmd_ready = 1'b1;
          next_state = S_IDLE;
        end else begin
          next_state = S_WAIT;
        end
      end
      S_WAIT: begin
        // Address held; wait out store or recall
        // The device ignores every pin here; strobes stay high, data floats, only the address is driven
        if ((cur.op == OP_HW_STORE || cur.op == OP_SW_STORE)
            ? (cnt >= 32'(COPY_CYC)) : (cnt >= 32'(RESTORE_CYC))) begin
          next_rsp_valid = 1'b1;
          next_cmd_ready = 1'b1;
          next_state = S_IDLE;
        end else begin
          next_cnt = cnt + 32'h1;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Register stage
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= S_BOOT;
      cur <= '0;
      cnt <= 32'h0;
      step <= 3'h0;
      ctl <= CTL_IDLE;
      address_lines <= 13'h0000;
      data_lines_out <= 8'h00;
      data_lines_oe_n <= 1'b1;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end else begin
      state <= next_state;
      cur <= next_cur;
      cnt <= next_cnt;
      step <= next_step;
      ctl <= next_ctl;
      address_lines <= next_address_lines;
      data_lines_out <= next_data_lines_out;
      data_lines_oe_n <= next_data_lines_oe_n;
      cmd_ready <= next_cmd_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
    end
  end

endmodule : nv_host_ctrl
`default_nettype wire

// ===== bench/nv_host_ctrl_props.sv
// Purpose: port checker for the nv host controller
// Assumes: pin phases as in nv_host_pkg
// Notes: bound to the design at the foot
`timescale 1ns/1ns
`default_nettype none
module nv_host_ctrl_props
  import nv_host_pkg::*;
#(parameter int COPY_CYC = 20, parameter int RESTORE_CYC = 10) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [DATA_W-1:0] rsp_data,
  input wire ctl_pins_t ctl,
  input wire logic [ADDR_W-1:0] address_lines,
  input wire logic [DATA_W-1:0] data_lines_in,
  input wire logic [DATA_W-1:0] data_lines_out,
  input wire logic data_lines_oe_n
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Accepted command
  wire logic take = cmd_valid && cmd_ready;
  wire logic sw = cmd.op == OP_SW_STORE || cmd.op == OP_SW_RECALL;
  ////////////////////////////////////////////////////////////////////////
  reset_idle_a: assert property ($fell(sys_rst) |-> ctl == 4'hf &&
    data_lines_oe_n && !cmd_ready) else $error("pins not idle after reset");
  read_pins_a: assert property (take && cmd.op == OP_READ |=>
    !ctl.chip_select_n && !ctl.output_gate_n && ctl.write_strobe_n &&
    address_lines == $past(cmd.addr)) else $error("read phase wrong");
  read_answer_a: assert property (take && cmd.op == OP_READ |->
    ##[6:7] rsp_valid) else $error("read answer late");
  write_gate_a: assert property (!data_lines_oe_n |->
    ctl.output_gate_n) else $error("gate low while driving");
  write_addr_a: assert property (!ctl.write_strobe_n &&
    $past(!ctl.write_strobe_n) |-> $stable(address_lines))
    else $error("address moved in write");
  store_float_a: assert property (!ctl.nonvolatile_strobe_n |->
    data_lines_oe_n) else $error("driving during nv cycle");
  recall_addr_a: assert property (!ctl.nonvolatile_strobe_n &&
    $past(!ctl.nonvolatile_strobe_n) |-> $stable(address_lines))
    else $error("address moved in nv cycle");
  sw_reads_a: assert property (take && sw |=>
    ctl.write_strobe_n [*8]) else $error("write in sequence");
  busy_refuse_a: assert property (take |=> !cmd_ready &&
    !rsp_valid) else $error("ready while busy");
  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than a cycle");
  write_data_a: assert property (!data_lines_oe_n &&
    $past(!data_lines_oe_n) |-> $stable(data_lines_out))
    else $error("write data moved");
  rsp_hold_a: assert property (rsp_valid |->
    $stable(rsp_data)) else $error("answer data moved");
  select_addr_a: assert property (!ctl.chip_select_n &&
    $past(!ctl.chip_select_n) |-> $stable(address_lines))
    else $error("address moved while selected");
  read_c: cover property (take && cmd.op == OP_READ);
  sw_c: cover property (take && sw);
  hw_c: cover property ($fell(ctl.nonvolatile_strobe_n));
endmodule : nv_host_ctrl_props
bind nv_host_ctrl nv_host_ctrl_props #(.COPY_CYC(COPY_CYC),
  .RESTORE_CYC(RESTORE_CYC)) i_props (.core_clk(core_clk),
  .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
  .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .ctl(ctl), .address_lines(address_lines), .data_lines_in(data_lines_in),
  .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n));
`default_nettype wire

// ===== bench/nv_sram_model.sv
// Purpose: behavioural non-volatile SRAM on the far side
// Assumes: pins sampled on core_clk, nv cycles finish at once
// Notes: idle data pins show a pattern that moves every cycle
`timescale 1ns/1ns
`default_nettype none
module nv_sram_model
  import nv_host_pkg::*;
(
  input wire logic core_clk,
  input wire ctl_pins_t ctl,
  input wire logic [12:0] address_lines,
  input wire logic [7:0] data_lines_in,
  output logic [7:0] dev_q
);
  logic [7:0] mem [8192];
  logic [7:0] nvm [8192];
  logic [12:0] seq [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
  logic [7:0] pat = 8'h00;
  logic pe = 0, pst = 0, prc = 0, st, rc;
  int step = 0;
  wire logic e = !ctl.chip_select_n;
  wire logic g = !ctl.output_gate_n;
  wire logic w = !ctl.write_strobe_n;
  wire logic n = !ctl.nonvolatile_strobe_n;
  // Read drive, floating otherwise
  assign dev_q = (e && g && !w && !n) ? mem[address_lines] : pat;
  // Write, store, recall and sequence tracking
  always @(posedge core_clk) begin
    pat = pat + 8'h5b;
    if (e && w && !n) mem[address_lines] = data_lines_in;
    // Supply taken as above the sense level: no store refused
    st = e && w && n && !g;
    rc = e && g && n && !w;
    if (st && !pst) nvm = mem;
    if (rc && !prc) mem = nvm;
    // Sequence reads never meet the strobe store state
    if (e && !pe && !w && !n) begin
      if (step == 5 && address_lines == SEQ_STORE) nvm = mem;
      if (step == 5 && address_lines == SEQ_RECALL) mem = nvm;
      step = (step < 5 && address_lines == seq[step]) ? step + 1 :
        int'(address_lines == SEQ_A0);
    end
    pe = e;
    pst = st;
    prc = rc;
  end
endmodule : nv_sram_model
`default_nettype wire

// ===== bench/nv_host_ctrl_tb.sv
// Purpose: self-checking bench for the nv host controller
// Assumes: shortened copy and restore counts
// Notes: every command notes its expected answer in a queue
`timescale 1ns/1ns
`default_nettype none
module nv_host_ctrl_tb import nv_host_pkg::*; ;
  localparam int CC = 20;
  localparam int RC = 10;
  logic core_clk = 0, sys_rst = 1, cmd_valid = 0;
  cmd_t cmd = '0;
  logic cmd_ready, rsp_valid, data_lines_oe_n;
  logic [7:0] rsp_data, data_lines_out, dev_q, data_lines_in;
  logic [12:0] address_lines;
  ctl_pins_t ctl;
  int n_errors = 0, n_tests = 0, cyc = 0;
  logic [8:0] exp_q [$];
  assign data_lines_in = data_lines_oe_n ? dev_q : data_lines_out;
  nv_host_ctrl #(.COPY_CYC(CC), .RESTORE_CYC(RC)) i_nv_host_ctrl (
    .core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .ctl(ctl), .address_lines(address_lines),
    .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
    .data_lines_oe_n(data_lines_oe_n));
  nv_sram_model i_nv_sram_model (.core_clk(core_clk), .ctl(ctl),
    .address_lines(address_lines), .data_lines_in(data_lines_in),
    .dev_q(dev_q));
  initial forever #10 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // One command, held until taken, then wait for its answer
  task automatic op_do(input op_t op, input logic [12:0] a,
      input logic [7:0] d, input logic [8:0] e);
    exp_q.push_back(e);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd = '{op, a, d};
    // Ready is settled at the falling edge; the next rising edge takes
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    do @(negedge core_clk); while (rsp_valid !== 1'b1);
  endtask : op_do
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end
  // Answer watcher, looks while the one-cycle answer stands
  always @(negedge core_clk) begin
    logic [8:0] e;
    if (rsp_valid === 1'b1) begin
      e = exp_q.pop_front();
      if (e[8]) check(rsp_data, e[7:0]);
    end
  end
  initial begin
    logic [12:0] a;
    logic [7:0] d;
    void'($urandom(32'hcdc652c4));
    repeat (20) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (RC) begin
      @(posedge core_clk);
      #1 check({7'h0, cmd_ready}, 8'h0);
    end
    @(posedge core_clk);
    #1 check({7'h0, cmd_ready}, 8'h1);
    // Back-to-back writes and reads, edges of the address space
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 13'h0 : (i == 1) ? 13'h1fff : 13'($urandom());
      d = 8'($urandom());
      op_do(OP_WRITE, a, d, 9'h0);
      op_do(OP_READ, a, 8'h0, {1'b1, d});
    end
    // Software then hardware store and repeated recall
    for (int k = 0; k < 2; k++) begin
      d = 8'h3c + 8'(k);
      op_do(OP_WRITE, 13'h0123, d, 9'h0);
      op_do(k ? OP_HW_STORE : OP_SW_STORE, 13'h0, 8'h0, 9'h0);
      op_do(OP_WRITE, 13'h0123, 8'hc3, 9'h0);
      op_do(OP_READ, 13'h0123, 8'h0, 9'h1c3);
      repeat (2) op_do(k ? OP_HW_RECALL : OP_SW_RECALL, 13'h0, 8'h0, 9'h0);
      op_do(OP_READ, 13'h0123, 8'h0, {1'b1, d});
    end
    close_out();
  end
endmodule : nv_host_ctrl_tb
`default_nettype wire
